// ---- logic/lmw_top.sv ----
// Mode, wake and slope control for four bus transceivers
// Behaviour
// - Early dominant is blocked until the host returns recessive.
// - Receive-only disables driver, keeps receiving; in chip normal or stop.
// - Wake mode set in stop, sleep, restart or normal; forced in fail-safe.
// - Wake is dominant longer than filter time, registered on rising edge.
// - After wake receive output stays low until mode changes or detection is rearmed.
// - Wake in stop or normal raises interrupt and status, mode unchanged.
// - Wake in sleep requests a move to restart, records source.
// - Wake from sleep leaves interrupt deasserted.
// - Mode field keeps reading wake code after wake.
// - Writing another mode then wake again rearms detection.
// - Entering stop, sleep or fail-safe rearms, including repeated stop.
// - Stop-mode wake enables watchdog when wake-watchdog bit set.
// - Transmit dominant beyond timeout disables driver, sets fail flag.
// - Driver returns once transmit input leaves dominant.
// - One bit disables transmit timeout for all channels.
// - Bus dominant beyond timeout in normal/receive-only sets fail flag.
// - Bus supply undervoltage forces receive-only behaviour.
// - Low slope bit, normal mode only, applies at chip select high.
// - Flash bit, normal mode only, disables slope at chip select high.
// - Off mode after reset, allowed except in fail-safe, wake ignored.
// - Transceiver normal mode accepted only in chip normal mode.
`timescale 1ns/10ps
module lmw_top
    import lmw_pkg::*;
#(
    parameter int ENABLE_CYCLES = ENABLE_CYC,
    parameter int FILT_CYCLES   = WAKE_FILT_CYC,
    parameter int TO_CYCLES     = DOM_TO_CYC
) (
    input  wire logic              clk,            // 20 MHz clock
    input  wire logic              rst_n,          // Sync reset, active low
    input  wire logic [2:0]        chip_mode,      // Current chip mode
    input  wire logic              mode_wr,        // Pulse: mode write
    input  wire logic [1:0]        mode_wdata,     // Mode code written
    input  wire logic [1:0]        mode_wch,       // Channel written
    input  wire logic              cfg_wr,         // Pulse: slope cfg write
    input  wire logic              low_slope_select, // Low slope request
    input  wire logic              flash_select,   // Flash request
    input  wire logic              spi_select_n,   // SPI chip select, low
    input  wire logic              tx_timeout_enable, // Timeout enable
    input  wire logic              wdog_on_bus_wake_en, // Wake watchdog
    input  wire logic              wdog_active,    // Watchdog now on
    input  wire logic              uv_in,          // Bus supply undervolt
    input  wire logic              status_clr,     // Clear wake and fail
    input  wire logic [NCH-1:0]    bus_tx_in,      // Host transmit pins
    input  wire logic [NCH-1:0]    bus_in,         // Bus levels
    output logic [NCH-1:0]         bus_drv,        // 0 drives dominant
    output logic [NCH-1:0]         bus_rx_out,     // Receive pins
    output logic [2*NCH-1:0]       mode_fields,    // Mode field readback
    output logic [NCH-1:0]         wake_status_reg, // Wake sources
    output logic [NCH-1:0]         fail_flags,     // Channel fail flags
    output logic                   int_n,          // Interrupt, active low
    output logic                   chip_goto_restart, // Pulse: to restart
    output logic                   wdog_enable_req, // Pulse: enable wdog
    output logic                   low_slope,      // Active low slope
    output logic                   flash_mode      // Slope control off
);
    logic [2*NCH-1:0] modes_r, modes_nxt;
    logic [NCH-1:0] rearm_r, rearm_nxt, wstat_r, wstat_nxt;
    logic [2:0] chip_q_r;
    logic ls_pend_r, ls_pend_nxt, fl_pend_r, fl_pend_nxt;
    logic ls_r, ls_nxt, fl_r, fl_nxt, int_n_r, int_n_nxt;
    logic rst_req_r, rst_req_nxt, wd_req_r, wd_req_nxt;
    logic cs_q_r;
    logic [NCH-1:0] ch_wake, ch_fail, ch_tx, ch_rx;
    logic enter_low, any_wake;

    // Repeated stop command shows as a mode_wr pulse while chip_mode stays unchanged
    assign enter_low = (chip_mode == CHIP_STOP || chip_mode == CHIP_SLEEP ||
                        chip_mode == CHIP_FAILSAFE) &&
                       (chip_mode != chip_q_r || mode_wr);
    assign any_wake = |ch_wake;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            lmw_ch_out_s co;
            lmw_channel #(
                .ENABLE_CYCLES (ENABLE_CYCLES),
                .FILT_CYCLES   (FILT_CYCLES),
                .TO_CYCLES     (TO_CYCLES)
            ) u_ch (
                .clk      (clk),
                .rst_n    (rst_n),
                .mode     (modes_r[2*g +: 2]),
                .rearm    (rearm_r[g]),
                .uv       (uv_in),
                .to_en    (tx_timeout_enable),
                .tx_in    (bus_tx_in[g]),
                .bus_in   (bus_in[g]),
                .fail_clr (status_clr),
                .q        (co)
            );
            assign ch_wake[g] = co.wake;
            assign ch_fail[g] = co.fail;
            assign ch_tx[g]   = co.tx_drive;
            assign ch_rx[g]   = co.rx_out;
        end
    endgenerate

    always_comb begin
        modes_nxt   = modes_r;
        rearm_nxt   = '0;
        wstat_nxt   = status_clr ? '0 : wstat_r;
        ls_pend_nxt = ls_pend_r;
        fl_pend_nxt = fl_pend_r;
        ls_nxt      = ls_r;
        fl_nxt      = fl_r;
        int_n_nxt   = status_clr ? 1'b1 : int_n_r;
        rst_req_nxt = 1'b0;
        wd_req_nxt  = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            if (mode_wr && mode_wch == i[1:0]) begin
                unique case (mode_wdata)
                    MODE_OFF: modes_nxt[2*i +: 2] = MODE_OFF;
                    MODE_NORM:
                        if (chip_mode == CHIP_NORMAL)
                            modes_nxt[2*i +: 2] = MODE_NORM;
                    MODE_RXO:
                        if (chip_mode == CHIP_NORMAL ||
                            chip_mode == CHIP_STOP)
                            modes_nxt[2*i +: 2] = MODE_RXO;
                    MODE_WAKE:
                        if (chip_mode != CHIP_FAILSAFE)
                            modes_nxt[2*i +: 2] = MODE_WAKE;
                endcase
            end
            if (chip_mode == CHIP_FAILSAFE)
                modes_nxt[2*i +: 2] = MODE_WAKE;
            if (enter_low)
                rearm_nxt[i] = 1'b1;
            // Status set wins over a clear in the same cycle
            if (ch_wake[i])
                wstat_nxt[i] = 1'b1;
        end
        if (any_wake) begin
            if (chip_mode == CHIP_STOP || chip_mode == CHIP_NORMAL)
                int_n_nxt = 1'b0;
            if (chip_mode == CHIP_SLEEP || chip_mode == CHIP_FAILSAFE)
                rst_req_nxt = 1'b1;
            if (chip_mode == CHIP_STOP && wdog_on_bus_wake_en && !wdog_active)
                wd_req_nxt = 1'b1;
        end
        if (cfg_wr && chip_mode == CHIP_NORMAL) begin
            ls_pend_nxt = low_slope_select;
            fl_pend_nxt = flash_select;
        end
        if (spi_select_n && !cs_q_r) begin
            ls_nxt = ls_pend_r;
            fl_nxt = fl_pend_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            modes_r         <= '0;
            rearm_r         <= '0;
            wstat_r         <= '0;
            chip_q_r        <= CHIP_NORMAL;
            cs_q_r          <= 1'b1;
            ls_pend_r       <= RST_LOW_SLOPE;
            fl_pend_r       <= RST_FLASH;
            ls_r            <= RST_LOW_SLOPE;
            fl_r            <= RST_FLASH;
            int_n_r         <= 1'b1;
            rst_req_r       <= 1'b0;
            wd_req_r        <= 1'b0;
            bus_drv         <= '1;
            bus_rx_out      <= '1;
            mode_fields     <= '0;
            wake_status_reg <= '0;
            fail_flags      <= '0;
            int_n           <= 1'b1;
            chip_goto_restart <= 1'b0;
            wdog_enable_req <= 1'b0;
            low_slope       <= RST_LOW_SLOPE;
            flash_mode      <= RST_FLASH;
        end else begin
            modes_r         <= modes_nxt;
            rearm_r         <= rearm_nxt;
            wstat_r         <= wstat_nxt;
            chip_q_r        <= chip_mode;
            cs_q_r          <= spi_select_n;
            ls_pend_r       <= ls_pend_nxt;
            fl_pend_r       <= fl_pend_nxt;
            ls_r            <= ls_nxt;
            fl_r            <= fl_nxt;
            int_n_r         <= int_n_nxt;
            rst_req_r       <= rst_req_nxt;
            wd_req_r        <= wd_req_nxt;
            bus_drv         <= ch_tx;
            bus_rx_out      <= ch_rx;
            mode_fields     <= modes_r;
            wake_status_reg <= wstat_r;
            fail_flags      <= ch_fail;
            int_n           <= int_n_r;
            chip_goto_restart <= rst_req_r;
            wdog_enable_req <= wd_req_r;
            low_slope       <= ls_r;
            flash_mode      <= fl_r;
        end
    end

    property p_norm_only_chip_normal;
        @(posedge clk) disable iff (!rst_n)
        (mode_wr && mode_wdata == MODE_NORM && chip_mode != CHIP_NORMAL &&
         modes_r[2*mode_wch +: 2] != MODE_NORM && chip_mode != CHIP_FAILSAFE)
        |=> modes_r[2*$past(mode_wch) +: 2] != MODE_NORM;
    endproperty
    a_norm_only_chip_normal:
        assert property (p_norm_only_chip_normal)
        else $error("normal mode accepted outside chip normal");
    property p_failsafe_wake;
        @(posedge clk) disable iff (!rst_n)
        (chip_mode == CHIP_FAILSAFE) |=> (modes_r == {NCH{MODE_WAKE}});
    endproperty
    a_failsafe_wake: assert property (p_failsafe_wake)
        else $error("fail-safe did not force wake mode");
    property p_wake_int;
        @(posedge clk) disable iff (!rst_n)
        (any_wake && chip_mode == CHIP_STOP && !status_clr) |-> ##2 !int_n;
    endproperty
    a_wake_int: assert property (p_wake_int)
        else $error("interrupt missing after stop wake");
    property p_sleep_no_int;
        @(posedge clk) disable iff (!rst_n)
        (any_wake && chip_mode == CHIP_SLEEP && int_n_r)
        |-> ##2 (int_n && chip_goto_restart);
    endproperty
    a_sleep_no_int: assert property (p_sleep_no_int)
        else $error("sleep wake handled wrongly");
    property p_slope_at_cs;
        @(posedge clk) disable iff (!rst_n)
        !(spi_select_n && !cs_q_r) |=> $stable(ls_r);
    endproperty
    a_slope_at_cs: assert property (p_slope_at_cs)
        else $error("slope changed without chip select rising");
    property p_rearm_stop;
        @(posedge clk) disable iff (!rst_n)
        (chip_mode == CHIP_STOP && chip_q_r != CHIP_STOP) |=> (&rearm_r);
    endproperty
    a_rearm_stop: assert property (p_rearm_stop)
        else $error("no rearm on stop entry");
    c_wake: cover property (@(posedge clk) disable iff (!rst_n) any_wake);
    c_fail: cover property (@(posedge clk) disable iff (!rst_n) |fail_flags);
    c_slope: cover property (@(posedge clk) disable iff (!rst_n) low_slope);
    c_restart: cover property (@(posedge clk) disable iff (!rst_n)
        chip_goto_restart);
    c_wdog: cover property (@(posedge clk) disable iff (!rst_n)
        wdog_enable_req);

    // Side effects of a wake, flash update timing and writes that must be refused
    property p_wd_req;
        @(posedge clk) disable iff (!rst_n)
        (any_wake && chip_mode == CHIP_STOP && wdog_on_bus_wake_en &&
         !wdog_active) |-> ##2 wdog_enable_req;
    endproperty
    a_wd_req: assert property (p_wd_req)
        else $error("watchdog not enabled after stop wake");

    property p_wd_only_stop;
        @(posedge clk) disable iff (!rst_n)
        !(any_wake && chip_mode == CHIP_STOP) |=> !wd_req_r;
    endproperty
    a_wd_only_stop: assert property (p_wd_only_stop)
        else $error("watchdog request without stop wake");

    property p_int_hold;
        @(posedge clk) disable iff (!rst_n)
        (!int_n_r && !status_clr) |=> !int_n_r;
    endproperty
    a_int_hold: assert property (p_int_hold)
        else $error("interrupt released without clear");

    property p_wake_status;
        @(posedge clk) disable iff (!rst_n)
        any_wake |-> ##2 (wake_status_reg != '0);
    endproperty
    a_wake_status: assert property (p_wake_status)
        else $error("wake source not recorded");

    property p_failsafe_restart;
        @(posedge clk) disable iff (!rst_n)
        (any_wake && chip_mode == CHIP_FAILSAFE) |-> ##2 chip_goto_restart;
    endproperty
    a_failsafe_restart: assert property (p_failsafe_restart)
        else $error("no restart after fail-safe wake");

    property p_flash_at_cs;
        @(posedge clk) disable iff (!rst_n)
        !(spi_select_n && !cs_q_r) |=> $stable(fl_r);
    endproperty
    a_flash_at_cs: assert property (p_flash_at_cs)
        else $error("flash changed without chip select rising");

    property p_rxo_refused;
        @(posedge clk) disable iff (!rst_n)
        (mode_wr && mode_wdata == MODE_RXO && chip_mode != CHIP_NORMAL &&
         chip_mode != CHIP_STOP && chip_mode != CHIP_FAILSAFE &&
         modes_r[2*mode_wch +: 2] != MODE_RXO)
        |=> modes_r[2*$past(mode_wch) +: 2] != MODE_RXO;
    endproperty
    a_rxo_refused: assert property (p_rxo_refused)
        else $error("receive-only accepted in wrong chip mode");
endmodule

// ---- logic/lmw_pkg.sv ----
// Package for the bus transceiver mode and wake control block
package lmw_pkg;
    localparam int NCH = 4;
    // Transceiver mode field codes
    localparam logic [1:0] MODE_OFF  = 2'h0;
    localparam logic [1:0] MODE_WAKE = 2'h1;
    localparam logic [1:0] MODE_RXO  = 2'h2;
    localparam logic [1:0] MODE_NORM = 2'h3;
    // Chip mode codes
    localparam logic [2:0] CHIP_NORMAL   = 3'h0;
    localparam logic [2:0] CHIP_STOP     = 3'h1;
    localparam logic [2:0] CHIP_SLEEP    = 3'h2;
    localparam logic [2:0] CHIP_RESTART  = 3'h3;
    localparam logic [2:0] CHIP_FAILSAFE = 3'h4;
    // Clock and times
    localparam int CLK_HZ        = 20000000;
    localparam int ENABLE_US     = 10;
    localparam int WAKE_FILT_US  = 150;
    localparam int DOM_TO_US     = 12000;
    localparam int ENABLE_CYC    = (ENABLE_US * (CLK_HZ / 1000000));
    localparam int WAKE_FILT_CYC = (WAKE_FILT_US * (CLK_HZ / 1000000));
    localparam int DOM_TO_CYC    = (DOM_TO_US * (CLK_HZ / 1000000));
    localparam int CNT_W         = 20;
    // Reset values
    localparam logic RST_LOW_SLOPE = 1'b0;
    localparam logic RST_FLASH     = 1'b0;

    typedef enum logic [1:0] {
        CH_IDLE  = 2'b00,
        CH_DOM   = 2'b01,
        CH_ARMED = 2'b11,
        CH_WOKEN = 2'b10
    } lmw_wake_e;

    typedef struct packed {
        logic       tx_drive;
        logic       rx_out;
        logic       fail;
        logic       wake;
    } lmw_ch_out_s;
endpackage

// ---- logic/lmw_channel.sv ----
// One transceiver channel: enable gate, timeouts, wake detect
`timescale 1ns/10ps
module lmw_channel
    import lmw_pkg::*;
#(
    parameter int ENABLE_CYCLES = ENABLE_CYC,
    parameter int FILT_CYCLES   = WAKE_FILT_CYC,
    parameter int TO_CYCLES     = DOM_TO_CYC
) (
    input  wire logic        clk,         // System clock
    input  wire logic        rst_n,       // Sync reset, active low
    input  wire logic [1:0]  mode,        // Mode field
    input  wire logic        rearm,       // Pulse: rearm wake detect
    input  wire logic        uv,          // Bus supply undervoltage
    input  wire logic        to_en,       // Transmit timeout enable
    input  wire logic        tx_in,       // Host transmit, 0 dominant
    input  wire logic        bus_in,      // Bus level, 0 dominant
    input  wire logic        fail_clr,    // Clear failure flag
    output lmw_pkg::lmw_ch_out_s q        // Channel outputs
);
    lmw_wake_e st_r, st_nxt;
    logic [CNT_W-1:0] en_cnt_r, en_cnt_nxt, wk_cnt_r, wk_cnt_nxt;
    logic [CNT_W-1:0] txd_cnt_r, txd_cnt_nxt, bus_cnt_r, bus_cnt_nxt;
    logic en_done_r, en_done_nxt, gate_r, gate_nxt, txto_r, txto_nxt;
    logic fail_r, fail_nxt, wake_p_r, wake_p_nxt;
    logic [1:0] mode_q_r;
    logic drv_mode, tx_ok;
    lmw_ch_out_s q_nxt;

    assign drv_mode = (mode == MODE_NORM) && !uv;
    assign tx_ok    = drv_mode && en_done_r && gate_r && !txto_r;

    always_comb begin
        en_cnt_nxt  = en_cnt_r;
        en_done_nxt = en_done_r;
        gate_nxt    = gate_r;
        txto_nxt    = txto_r;
        txd_cnt_nxt = txd_cnt_r;
        bus_cnt_nxt = bus_cnt_r;
        wk_cnt_nxt  = wk_cnt_r;
        fail_nxt    = fail_r && !fail_clr;
        st_nxt      = st_r;
        wake_p_nxt  = 1'b0;
        // Enable time, restarted on each entry into a driving mode
        if (!drv_mode || mode != mode_q_r) begin
            en_cnt_nxt  = '0;
            en_done_nxt = 1'b0;
            gate_nxt    = 1'b0;
        end else if (!en_done_r) begin
            if (en_cnt_r >= CNT_W'(ENABLE_CYCLES - 1))
                en_done_nxt = 1'b1;
            else
                en_cnt_nxt = en_cnt_r + 1'b1;
        end else if (tx_in) begin
            // Early dominant is held back until host goes recessive
            gate_nxt = 1'b1;
        end
        // Transmit dominant timeout
        if (tx_in || !to_en) begin
            txd_cnt_nxt = '0;
            txto_nxt    = 1'b0;
        end else if (txd_cnt_r < CNT_W'(TO_CYCLES)) begin
            txd_cnt_nxt = txd_cnt_r + 1'b1;
        end else if (drv_mode) begin
            txto_nxt = 1'b1;
            fail_nxt = 1'b1;
        end
        // Bus dominant clamping in receiving modes
        if (bus_in || !(mode == MODE_NORM || mode == MODE_RXO)) begin
            bus_cnt_nxt = '0;
        end else if (bus_cnt_r < CNT_W'(TO_CYCLES)) begin
            bus_cnt_nxt = bus_cnt_r + 1'b1;
        end else begin
            fail_nxt = 1'b1;
        end
        // Wake detection
        if (mode != MODE_WAKE || rearm) begin
            st_nxt     = CH_IDLE;
            wk_cnt_nxt = '0;
        end else begin
            unique case (st_r)
                CH_IDLE: begin
                    wk_cnt_nxt = '0;
                    if (!bus_in)
                        st_nxt = CH_DOM;
                end
                CH_DOM: begin
                    if (bus_in)
                        st_nxt = CH_IDLE;
                    else if (wk_cnt_r >= CNT_W'(FILT_CYCLES))
                        st_nxt = CH_ARMED;
                    else
                        wk_cnt_nxt = wk_cnt_r + 1'b1;
                end
                CH_ARMED: begin
                    if (bus_in) begin
                        st_nxt     = CH_WOKEN;
                        wake_p_nxt = 1'b1;
                    end
                end
                CH_WOKEN: st_nxt = CH_WOKEN;
            endcase
        end
        q_nxt.tx_drive = tx_ok ? tx_in : 1'b1;
        q_nxt.rx_out   = (st_r == CH_WOKEN) ? 1'b0 :
                         (mode == MODE_NORM || mode == MODE_RXO) ? bus_in
                         : 1'b1;
        q_nxt.fail     = fail_r;
        q_nxt.wake     = wake_p_r;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r      <= CH_IDLE;
            en_cnt_r  <= '0;
            wk_cnt_r  <= '0;
            txd_cnt_r <= '0;
            bus_cnt_r <= '0;
            en_done_r <= 1'b0;
            gate_r    <= 1'b0;
            txto_r    <= 1'b0;
            fail_r    <= 1'b0;
            wake_p_r  <= 1'b0;
            mode_q_r  <= MODE_OFF;
            q         <= '{tx_drive: 1'b1, rx_out: 1'b1, fail: 1'b0,
                           wake: 1'b0};
        end else begin
            st_r      <= st_nxt;
            en_cnt_r  <= en_cnt_nxt;
            wk_cnt_r  <= wk_cnt_nxt;
            txd_cnt_r <= txd_cnt_nxt;
            bus_cnt_r <= bus_cnt_nxt;
            en_done_r <= en_done_nxt;
            gate_r    <= gate_nxt;
            txto_r    <= txto_nxt;
            fail_r    <= fail_nxt;
            wake_p_r  <= wake_p_nxt;
            mode_q_r  <= mode;
            q         <= q_nxt;
        end
    end

    property p_no_early_dom;
        @(posedge clk) disable iff (!rst_n)
        (!en_done_r) |=> q.tx_drive;
    endproperty
    a_no_early_dom: assert property (p_no_early_dom)
        else $error("dominant driven before enable time");
    property p_woken_rx_low;
        @(posedge clk) disable iff (!rst_n)
        (st_r == CH_WOKEN && mode == MODE_WAKE) |=> !q.rx_out;
    endproperty
    a_woken_rx_low: assert property (p_woken_rx_low)
        else $error("receive output not low after wake");
    property p_uv_no_drive;
        @(posedge clk) disable iff (!rst_n)
        uv |=> q.tx_drive;
    endproperty
    a_uv_no_drive: assert property (p_uv_no_drive)
        else $error("driver active in undervoltage");
    property p_off_no_wake;
        @(posedge clk) disable iff (!rst_n)
        (mode == MODE_OFF) |=> (st_r == CH_IDLE);
    endproperty
    a_off_no_wake: assert property (p_off_no_wake)
        else $error("wake logic active in off mode");
endmodule

// ---- bench/lmw_bus_model.sv ----
// Bus partner: a remote node that can pull each channel's line dominant
`timescale 1ns/10ps
module lmw_bus_model
    import lmw_pkg::*;
(
    input  wire logic [lmw_pkg::NCH-1:0] drv,    // Device driver, 0 dominant
    input  wire logic [lmw_pkg::NCH-1:0] remote, // 1 pulls the line dominant
    output logic [lmw_pkg::NCH-1:0]      line    // Wired-AND bus level
);
    // Pull-up: a released line always settles recessive, never stale
    assign line = drv & ~remote;
endmodule

// ---- bench/tb.sv ----
// Testbench for the transceiver mode, wake and slope control block
`timescale 1ns/10ps
module tb;
    import lmw_pkg::*;
    localparam int EN_C = 4;
    localparam int FI_C = 8;
    localparam int TO_C = 20;
    logic clk = 1'b0, rst_n = 1'b0, mode_wr = 1'b0, cfg_wr = 1'b0;
    logic [2:0] chip_mode = CHIP_STOP;
    logic [1:0] mode_wdata = 2'h0, mode_wch = 2'h0;
    logic lss = 1'b0, fls = 1'b0, spi_select_n = 1'b1, to_en = 1'b1;
    logic wd_en = 1'b0, wd_act = 1'b0, uv_in = 1'b0, clr = 1'b0;
    logic [3:0] tx = 4'hf, remote = 4'h0, bus_in, drv, rx, wk, fl;
    logic [7:0] mf;
    logic int_n, to_rst, wd_req, low_slope, flash_mode;
    int n_fail = 0, tests_run = 0, n_rst = 0, n_wd = 0;
    always #25 clk = ~clk;
    lmw_bus_model bus (.drv(drv), .remote(remote), .line(bus_in));
    lmw_top #(.ENABLE_CYCLES(EN_C), .FILT_CYCLES(FI_C), .TO_CYCLES(TO_C)) dut (
        .clk(clk), .rst_n(rst_n), .chip_mode(chip_mode), .mode_wr(mode_wr),
        .mode_wdata(mode_wdata), .mode_wch(mode_wch), .cfg_wr(cfg_wr),
        .low_slope_select(lss), .flash_select(fls),
        .spi_select_n(spi_select_n), .tx_timeout_enable(to_en),
        .wdog_on_bus_wake_en(wd_en), .wdog_active(wd_act), .uv_in(uv_in),
        .status_clr(clr), .bus_tx_in(tx), .bus_in(bus_in), .bus_drv(drv),
        .bus_rx_out(rx), .mode_fields(mf), .wake_status_reg(wk),
        .fail_flags(fl), .int_n(int_n), .chip_goto_restart(to_rst),
        .wdog_enable_req(wd_req), .low_slope(low_slope),
        .flash_mode(flash_mode));
    // Pulses are counted as they pass so no single-cycle event is missed
    always @(posedge clk) begin
        if (to_rst === 1'b1) n_rst++;
        if (wd_req === 1'b1) n_wd++;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask
    task automatic wr_mode(input logic [1:0] ch, input logic [1:0] code);
        mode_wch = ch;
        mode_wdata = code;
        mode_wr = 1'b1;
        step(1);
        mode_wr = 1'b0;
        step(3);
    endtask
    task automatic dom(input int ch, input int n);
        remote[ch] = 1'b1;
        step(n);
        remote[ch] = 1'b0;
        step(6);
    endtask
    task automatic clear_status();
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        step(2);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #(3000 * 50);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        step(3);
        rst_n = 1'b1;
        step(1);
        chk({drv, rx}, 8'hff);
        chk({mf[7:1], int_n, low_slope, flash_mode}, 8'h04);
        wr_mode(0, MODE_NORM);
        chk(mf, 8'h00);
        wr_mode(0, MODE_RXO);
        chk(mf[1:0], MODE_RXO);
        tx[0] = 1'b0;
        remote[0] = 1'b1;
        step(4);
        chk({drv[0], rx[0]}, 8'h2);
        remote[0] = 1'b0;
        chip_mode = CHIP_NORMAL;
        // Host breaks the enable wait on purpose: dominant held from the write
        wr_mode(0, MODE_NORM);
        step(EN_C + 6);
        chk(drv[0], 1'b1);
        chk(mf[1:0], MODE_NORM);
        tx[0] = 1'b1;
        step(3);
        tx[0] = 1'b0;
        step(3);
        chk(drv[0], 1'b0);
        step(TO_C + 4);
        chk({fl[0], drv[0]}, 8'h3);
        tx[0] = 1'b1;
        step(3);
        clear_status();
        tx[0] = 1'b0;
        step(3);
        chk(drv[0], 1'b0);
        to_en = 1'b0;
        step(TO_C + 5);
        chk(drv[0], 1'b0);
        chk({fl[0], mf[1:0]}, {1'b1, MODE_NORM});
        tx[0] = 1'b1;
        to_en = 1'b1;
        uv_in = 1'b1;
        step(2);
        tx[0] = 1'b0;
        step(4);
        chk(drv[0], 1'b1);
        tx[0] = 1'b1;
        uv_in = 1'b0;
        step(EN_C + 3);
        tx[0] = 1'b0;
        step(4);
        chk(drv[0], 1'b0);
        tx[0] = 1'b1;
        step(2);
        clear_status();
        wr_mode(1, MODE_WAKE);
        dom(1, FI_C - 3);
        chk({wk, int_n}, 8'h01);
        remote[1] = 1'b1;
        step(FI_C + 4);
        chk(wk, 4'h0);
        remote[1] = 1'b0;
        step(6);
        chk({wk, int_n, rx[1]}, 8'h08);
        chk({mf[3:2], n_rst[0]}, {MODE_WAKE, 1'b0});
        step(20);
        chk(rx[1], 1'b0);
        wr_mode(1, MODE_OFF);
        chk(rx[1], 1'b1);
        clear_status();
        dom(1, FI_C + 4);
        chk({wk, int_n}, 8'h01);
        wr_mode(1, MODE_WAKE);
        dom(1, FI_C + 4);
        chk(wk, 4'h2);
        clear_status();
        chip_mode = CHIP_STOP;
        wd_en = 1'b1;
        step(3);
        dom(1, FI_C + 4);
        chk({n_wd[1:0], wk, int_n}, 8'h24);
        clear_status();
        wr_mode(2, MODE_OFF);
        dom(1, FI_C + 4);
        chk({wk, int_n}, 8'h04);
        clear_status();
        wd_en = 1'b0;
        chip_mode = CHIP_SLEEP;
        step(3);
        wr_mode(3, MODE_WAKE);
        chk(mf[7:6], MODE_WAKE);
        dom(1, FI_C + 4);
        chk({n_rst[1:0], wk, int_n, rx[1]}, 8'h4a);
        chip_mode = CHIP_FAILSAFE;
        step(4);
        chk(mf[1:0], MODE_WAKE);
        chip_mode = CHIP_NORMAL;
        spi_select_n = 1'b0;
        lss = 1'b1;
        fls = 1'b1;
        cfg_wr = 1'b1;
        step(1);
        cfg_wr = 1'b0;
        step(3);
        chk({low_slope, flash_mode}, 8'h0);
        spi_select_n = 1'b1;
        step(3);
        chk({low_slope, flash_mode}, 8'h3);
        chip_mode = CHIP_STOP;
        spi_select_n = 1'b0;
        lss = 1'b0;
        fls = 1'b0;
        cfg_wr = 1'b1;
        step(1);
        cfg_wr = 1'b0;
        spi_select_n = 1'b1;
        step(3);
        chk({low_slope, flash_mode}, 8'h3);
        tally_and_finish();
    end
endmodule
